// *** src/mcu_core_special_registers.sv ***
`include "core_regs_map.svh"

module mcu_core_special_registers
   import core_regs_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register access
   input  wire logic [5:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Instruction events
   input  core_op_type      op,
   input  wire logic [9:0]  operand,
   input  wire logic [7:0]  accumulator,
   input  wire logic        flag_wr,
   input  wire logic [2:0]  flags_in,
   // Counter sources
   input  wire logic        tick_16k,
   input  wire logic        instr_cycle,
   input  wire logic        counter_control_setting,
   // Watchdog
   input  wire logic        watchdog_timeout,
   // Core state
   output logic      [11:0] program_counter,
   output logic      [7:0]  status_out,
   output logic      [7:0]  ram_select_out,
   output logic      [7:0]  program_page_out,
   output logic             acc_restore_valid,
   output logic      [7:0]  acc_restore_data
);

   // ==========================================================
   // State
   logic [11:0] pc_q;
   logic [11:0] pc_d;
   logic [7:0]  status_q;
   logic [7:0]  status_d;
   logic [7:0]  ram_select_q;
   logic [3:0]  page_q;
   logic [3:0]  page_d;
   logic [7:0]  free_counter_q;
   logic [7:0]  saved_acc_q;
   logic [7:0]  saved_status_q;
   logic [3:0]  saved_page_q;
   logic [7:0]  rd_spec_q;
   logic        rd_ram_q;
   logic [11:0] stack_top;
   logic [7:0]  ram_rdata;

   // Maps a data address onto the RAM array; 10h..1Fh ignore the bank.
   function automatic logic [7:0] ram_index(input logic [5:0] addr, input logic [1:0] bank);
      logic [7:0] idx;
      idx = 8'h00;
      if (addr[5]) begin
         idx = {1'b0, bank, addr[4:0]} + `RAM_BANKED_BASE;
      end else begin
         idx = {4'h0, addr[3:0]};
      end
      return idx;
   endfunction

   // ==========================================================
   // Address decode
   wire [1:0] ram_bank_sel   = ram_select_q[7:6];
   wire [5:0] ram_index_bits = ram_select_q[5:0];
   wire [1:0] reg_page_sel   = status_q[7:6];
   wire [5:0] eff_addr       = (reg_addr == `ADDR_INDIRECT) ? ram_index_bits : reg_addr;
   wire       is_ram         = eff_addr >= `ADDR_GLOBAL_LO;
   wire [7:0] ram_addr       = ram_index(eff_addr, ram_bank_sel);
   wire       wr_spec        = reg_wr && !is_ram;
   wire       sel_counter    = eff_addr == `ADDR_FREE_COUNTER;
   wire       sel_pc         = eff_addr == `ADDR_PROGRAM_CNT;
   wire       sel_status     = eff_addr == `ADDR_STATUS;
   wire       sel_ram_select = eff_addr == `ADDR_RAM_SELECT;
   wire       sel_page       = (eff_addr == `ADDR_PROGRAM_PAGE) && (reg_page_sel == `PAGE_PAGE0);

   // ==========================================================
   // Program counter
   wire [1:0]  code_page   = page_q[1:0];
   wire [11:0] pc_plus_one = pc_q + 12'h001;
   wire        load_pc_reg = wr_spec && sel_pc;
   wire [7:0]  pc_low_src  = (op == OP_MOV_PC) ? accumulator : reg_wdata;
   wire [7:0]  pc_low_sum  = pc_q[7:0] + accumulator;
   wire        is_return   = (op == OP_RETURN) || (op == OP_LITERAL_RETURN) || (op == OP_INTERRUPT_RETURN);
   wire        stack_push  = (op == OP_CALL) || (op == OP_INTERRUPT);
   wire [11:0] push_value  = (op == OP_CALL) ? pc_plus_one : pc_q;

   always_comb begin
      pc_d = pc_q;
      unique case (op)
         OP_STEP:             pc_d = pc_plus_one;
         OP_JUMP:             pc_d = {code_page, operand};
         OP_CALL:             pc_d = {code_page, operand};
         OP_RETURN,
         OP_LITERAL_RETURN,
         OP_INTERRUPT_RETURN: pc_d = stack_top;
         OP_MOV_PC:           pc_d = {code_page, 2'b00, pc_low_src};
         OP_ADD_PC:           pc_d = {code_page, 2'b00, pc_low_sum};
         OP_TABLE_JUMP:       pc_d = {pc_q[11:8], pc_low_sum};
         OP_INTERRUPT:        pc_d = `INT_VECTOR;
         OP_NONE,
         OP_PAGE,
         OP_WATCHDOG_CLEAR,
         OP_SLEEP: begin
            if (load_pc_reg) begin
               pc_d = {code_page, 2'b00, pc_low_src};
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_q <= `PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   return_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (12)
   ) u_stack (
      .clk       (clk),
      .nrst      (nrst),
      .push      (stack_push),
      .pop       (is_return),
      .push_data (push_value),
      .top       (stack_top)
   );

   // ==========================================================
   // Status register
   always_comb begin
      status_d = status_q;
      if (flag_wr) begin
         status_d[2:0] = flags_in;
      end
      if (wr_spec && sel_status) begin
         status_d = (reg_wdata & `STATUS_WR_MASK) | (status_q & ~`STATUS_WR_MASK);
      end
      if (watchdog_timeout) begin
         status_d[`STATUS_TIMEOUT_BIT] = 1'b0;
      end
      if (op == OP_SLEEP) begin
         status_d[`STATUS_TIMEOUT_BIT] = 1'b1;
         status_d[`STATUS_PWRDN_BIT]   = 1'b0;
      end
      if (op == OP_WATCHDOG_CLEAR) begin
         status_d[`STATUS_TIMEOUT_BIT] = 1'b1;
         status_d[`STATUS_PWRDN_BIT]   = 1'b1;
      end
      if (op == OP_INTERRUPT_RETURN) begin
         status_d = saved_status_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= `STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ==========================================================
   // RAM select and program page registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ram_select_q <= `RAM_SELECT_RESET;
      end else if (wr_spec && sel_ram_select) begin
         ram_select_q <= reg_wdata;
      end
   end

   always_comb begin
      page_d = page_q;
      if (wr_spec && sel_page) begin
         page_d = reg_wdata[3:0];
      end
      if (op == OP_PAGE) begin
         page_d[1:0] = operand[1:0];
      end
      if (op == OP_INTERRUPT_RETURN) begin
         page_d = saved_page_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         page_q <= `PAGE_RESET;
      end else begin
         page_q <= page_d;
      end
   end

   // ==========================================================
   // Interrupt context save
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         saved_acc_q    <= 8'h00;
         saved_status_q <= `STATUS_RESET;
         saved_page_q   <= `PAGE_RESET;
      end else if (op == OP_INTERRUPT) begin
         saved_acc_q    <= accumulator;
         saved_status_q <= status_q;
         saved_page_q   <= page_q;
      end
   end

   assign acc_restore_valid = op == OP_INTERRUPT_RETURN;
   assign acc_restore_data  = saved_acc_q;

   // ==========================================================
   // Free counter
   wire counter_inc = counter_control_setting ? instr_cycle : tick_16k;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         free_counter_q <= 8'h00;
      end else if (wr_spec && sel_counter) begin
         free_counter_q <= reg_wdata;
      end else if (counter_inc) begin
         free_counter_q <= free_counter_q + 8'h01;
      end
   end

   // ==========================================================
   // Data RAM and read path
   general_ram #(
      .WIDTH (8),
      .DEPTH (`RAM_WORDS),
      .AW    (8)
   ) u_ram (
      .clk   (clk),
      .nrst  (nrst),
      .we    (reg_wr && is_ram),
      .waddr (ram_addr),
      .wdata (reg_wdata),
      .re    (reg_rd && is_ram),
      .raddr (ram_addr),
      .rdata (ram_rdata)
   );

   wire [7:0] spec_rdata = sel_counter    ? free_counter_q :
                           sel_pc         ? pc_q[7:0] :
                           sel_status     ? status_q :
                           sel_ram_select ? ram_select_q :
                           sel_page       ? {4'h0, page_q} : 8'h00;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_spec_q <= 8'h00;
         rd_ram_q  <= 1'b0;
      end else if (reg_rd) begin
         rd_spec_q <= spec_rdata;
         rd_ram_q  <= is_ram;
      end
   end

   assign reg_rdata        = rd_ram_q ? ram_rdata : rd_spec_q;
   assign program_counter  = pc_q;
   assign status_out       = status_q;
   assign ram_select_out   = ram_select_q;
   assign program_page_out = {4'h0, page_q};
endmodule

// *** src/core_regs_map.svh ***
`ifndef CORE_REGS_MAP_SVH
`define CORE_REGS_MAP_SVH
// Summary of operation
// - Accesses to the indirect pointer location reach the register or RAM cell named by ram select.
// - Free counter counts slow ticks or instruction cycles; ordinary read and write.
// - Program counter is 12 bits wide, addressing 4k words of 13-bit code.
// - Jump loads the low 10 counter bits from the operand.
// - Call pushes current address plus one, then loads the low 10 bits.
// - All three return kinds reload the counter from the stack top.
// - Accumulator move to counter: low byte from accumulator, bits 8 and 9 cleared.
// - Accumulator add to counter: relative add on low byte, bits 8 and 9 cleared.
// - Table jump: relative add on low byte, bits 8 and 9 kept.
// - Jump, call, add and move load the top two bits from the code page select.
// - A taken interrupt vectors to address 08h in code page 0.
// - Interrupt entry saves accumulator, status and page register; interrupt return restores them.
// - Status bits 0, 1, 2 hold carry, nibble carry and zero; all read and write.
// - Power-down flag bit 3: set at power on and watchdog clear, cleared by sleep.
// - Time-out flag bit 4: set at power up, sleep, watchdog clear; cleared by timeout.
// - Flag pairs after events follow from the set and clear actions above.
// - Status bit 5 selects control space page 0 or 1; resets to 0.
// - Status bits 7:6 select special register page 0 to 3; reset to 0.
// - Low six bits of ram select form the indirect address.
// - Ram select bits 7:6 pick one of four banks for 20h to 3Fh; reset 0.
// - Page register bits 1:0 hold the code page; the page instruction also writes them.
// - Addresses 10h to 1Fh are global; bank select applies only to 20h to 3Fh.

// ==========================================================
// Register locations
`define ADDR_INDIRECT      6'h00
`define ADDR_FREE_COUNTER  6'h01
`define ADDR_PROGRAM_CNT   6'h02
`define ADDR_STATUS        6'h03
`define ADDR_RAM_SELECT    6'h04
`define ADDR_PROGRAM_PAGE  6'h05
`define ADDR_GLOBAL_LO     6'h10
`define RAM_BANKED_BASE    8'h10
`define RAM_WORDS          144

// ==========================================================
// Field positions and reset values
`define STATUS_TIMEOUT_BIT 4
`define STATUS_PWRDN_BIT   3
`define STATUS_WR_MASK     8'hE7
`define STATUS_RESET       8'h18
`define RAM_SELECT_RESET   8'h00
`define PAGE_RESET         4'h0
`define PAGE_PAGE0         2'h0
`define INT_VECTOR         12'h008
`define PC_RESET           12'h000
`endif

// *** src/core_regs_pkg.sv ***
package core_regs_pkg;
   // Instruction events seen by the special register set.
   typedef enum logic [3:0] {
      OP_NONE,
      OP_STEP,
      OP_JUMP,
      OP_CALL,
      OP_RETURN,
      OP_LITERAL_RETURN,
      OP_INTERRUPT_RETURN,
      OP_MOV_PC,
      OP_ADD_PC,
      OP_TABLE_JUMP,
      OP_PAGE,
      OP_WATCHDOG_CLEAR,
      OP_SLEEP,
      OP_INTERRUPT
   } core_op_type;
endpackage

// *** src/return_stack.sv ***
module return_stack #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 12
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Stack operations
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] entry_q [DEPTH];
   logic [PW-1:0]    ptr_q;
   wire  [PW-1:0]    top_idx = ptr_q - 1'b1;

   // The pointer wraps, so a push beyond the depth overwrites the oldest entry.
   assign top = entry_q[top_idx];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= '0;
      end else if (push) begin
         ptr_q <= ptr_q + 1'b1;
      end else if (pop) begin
         ptr_q <= top_idx;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry_q[i] <= '0;
         end
      end else if (push) begin
         entry_q[ptr_q] <= push_data;
      end
   end
endmodule

// *** src/general_ram.sv ***
module general_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 144,
   parameter int AW    = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // Read port
   input  wire logic             re,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_q;

   assign rdata = rdata_q;

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (re) begin
         rdata_q <= mem[raddr];
      end
   end
endmodule

// *** verif/core_regs_checker.sv ***
module core_regs_checker
   import core_regs_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Register access
   input wire logic [5:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Instruction events
   input wire core_op_type op,
   input wire logic [9:0]  operand,
   input wire logic [7:0]  accumulator,
   input wire logic        flag_wr,
   input wire logic [2:0]  flags_in,
   // Counter sources and watchdog
   input wire logic        tick_16k,
   input wire logic        instr_cycle,
   input wire logic        counter_control_setting,
   input wire logic        watchdog_timeout,
   // Core state
   input wire logic [11:0] program_counter,
   input wire logic [7:0]  status_out,
   input wire logic [7:0]  ram_select_out,
   input wire logic [7:0]  program_page_out,
   input wire logic        acc_restore_valid,
   input wire logic [7:0]  acc_restore_data
);
   // ==========================================================
   // Program counter loading
   logic [1:0] pg;
   assign pg = program_page_out[1:0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   chk_jump_target: assert property (
      op == OP_JUMP |=> program_counter == {$past(pg), $past(operand)}) else $error("jump target wrong");
   chk_call_target: assert property (
      op == OP_CALL |=> program_counter == {$past(pg), $past(operand)}) else $error("call target wrong");
   chk_mov_pc: assert property (
      op == OP_MOV_PC |=> program_counter == {$past(pg), 2'h0, $past(accumulator)}) else $error("move to pc wrong");
   chk_add_pc: assert property (
      op == OP_ADD_PC |=> program_counter == {$past(pg), 2'h0, 8'($past(program_counter[7:0]) + $past(accumulator))})
      else $error("add to pc wrong");
   chk_table_jump: assert property (
      op == OP_TABLE_JUMP |=> program_counter == {$past(program_counter[11:8]),
         8'($past(program_counter[7:0]) + $past(accumulator))}) else $error("table jump wrong");
   chk_step_pc: assert property (
      op == OP_STEP && !reg_wr |=> program_counter == $past(program_counter) + 12'h001) else $error("step wrong");
   chk_int_vector: assert property (
      op == OP_INTERRUPT |=> program_counter == 12'h008) else $error("interrupt vector wrong");
   chk_restore_strobe: assert property (
      acc_restore_valid == (op == OP_INTERRUPT_RETURN)) else $error("restore strobe wrong");
   // ==========================================================
   // Status and select registers
   chk_sleep_flags: assert property (
      op == OP_SLEEP |=> status_out[4:3] == 2'h2) else $error("sleep flags wrong");
   chk_wdc_flags: assert property (
      op == OP_WATCHDOG_CLEAR |=> status_out[4:3] == 2'h3) else $error("watchdog clear flags wrong");
   chk_timeout_flag: assert property (
      watchdog_timeout && op inside {OP_NONE, OP_STEP} && !reg_wr |=> !status_out[4])
      else $error("timeout flag not cleared");
   chk_status_write: assert property (
      reg_wr && reg_addr == 6'h03 && op == OP_NONE && !flag_wr && !watchdog_timeout |=>
      status_out == {$past(reg_wdata[7:5]), $past(status_out[4:3]), $past(reg_wdata[2:0])})
      else $error("status write wrong");
   chk_ramsel_write: assert property (
      reg_wr && reg_addr == 6'h04 |=> ram_select_out == $past(reg_wdata)) else $error("ram select write wrong");
   cover property (op == OP_CALL ##2 op == OP_RETURN);
   cover property (op == OP_INTERRUPT_RETURN);
   cover property (reg_wr && reg_addr == 6'h00);
endmodule

bind mcu_core_special_registers core_regs_checker #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.clk, .nrst, .reg_addr,
   .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .op, .operand, .accumulator, .flag_wr, .flags_in, .tick_16k,
   .instr_cycle, .counter_control_setting, .watchdog_timeout, .program_counter, .status_out, .ram_select_out,
   .program_page_out, .acc_restore_valid, .acc_restore_data);

// *** verif/testbench.sv ***
module testbench
   import core_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [11:0] v; logic [1:0] k;} note_type;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_rd = 1'b0;
   core_op_type op = OP_NONE;
   logic [9:0]  operand = 10'h000;
   logic [7:0]  accumulator = 8'h00;
   logic        flag_wr = 1'b0;
   logic [2:0]  flags_in = 3'h0;
   logic        tick_16k = 1'b0;
   logic        instr_cycle = 1'b0;
   logic        counter_control_setting = 1'b0;
   logic        watchdog_timeout = 1'b0;
   logic [11:0] program_counter;
   logic [7:0]  status_out, ram_select_out, program_page_out, acc_restore_data, reg_rdata;
   logic        acc_restore_valid;
   logic        watch_pc = 1'b0, rd_seen = 1'b0, ev_seen = 1'b0;
   core_op_type last_op = OP_NONE;
   logic [11:0] m_pc = 12'h000, ret;
   logic [7:0]  st, sav_acc;
   logic [31:0] r;
   logic [1:0]  tp [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
   string       nm [3] = '{"reg_rdata", "program_counter", "acc_restore_data"};
   note_type    q [$];
   int          bad_count = 0, tests_run = 0, cycles = 0;

   mcu_core_special_registers #(.STACK_DEPTH(8)) dut (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .op, .operand, .accumulator, .flag_wr, .flags_in, .tick_16k, .instr_cycle,
      .counter_control_setting, .watchdog_timeout, .program_counter, .status_out, .ram_select_out,
      .program_page_out, .acc_restore_valid, .acc_restore_data);

   always #50 clk = ~clk;

   // ==========================================================
   // Drivers
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      q.push_back('{{4'h0, e}, 2'h0});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ev(input core_op_type o, input logic [9:0] d, input logic [7:0] a, input logic c,
                     input logic [11:0] e);
      if (c) q.push_back('{e, 2'h1});
      if (c && o == OP_INTERRUPT_RETURN) q.push_back('{{4'h0, sav_acc}, 2'h2});
      if (c) m_pc = e;
      op <= o;
      operand <= d;
      accumulator <= a;
      watch_pc <= c;
      @(posedge clk);
      op <= OP_NONE;
      watch_pc <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input int w, input int n);
      repeat (n) begin
         tick_16k <= (w == 0);
         instr_cycle <= (w == 1);
         watchdog_timeout <= (w == 2);
         flag_wr <= (w == 3);
         @(posedge clk);
         {tick_16k, instr_cycle, watchdog_timeout, flag_wr} <= 4'h0;
         @(posedge clk);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Result monitor: each result that appears takes the oldest note.
   task automatic take(input logic [1:0] k, input logic [11:0] seen);
      note_type n;
      n.v = 'x;
      n.k = k;
      if (q.size() != 0) n = q.pop_front();
      tests_run++;
      if (n.k !== k || n.v !== seen) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm[k], n.v, seen);
      end
   endtask
   always @(posedge clk) begin
      if (rd_seen) take(2'h0, {4'h0, reg_rdata});
      if (ev_seen) take(2'h1, program_counter);
      if (ev_seen && last_op == OP_INTERRUPT_RETURN) take(2'h2, {4'h0, acc_restore_data});
      rd_seen <= reg_rd;
      ev_seen <= watch_pc;
      last_op <= op;
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         stop_test();
      end
   end

   // ==========================================================
   // Scenarios
   initial begin
      void'($urandom(7354));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(6'h03, 8'h18);
      rd(6'h04, 8'h00);
      rd(6'h05, 8'h00);
      rd(6'h01, 8'h00);
      $display("reset values done");
      r = $urandom();
      wr(6'h03, r[7:0]);
      rd(6'h03, {r[7:5], 2'h3, r[2:0]});
      wr(6'h07, 8'h5A);
      rd(6'h07, 8'h00);
      wr(6'h03, 8'h00);
      $display("status access done");
      for (int b = 0; b < 4; b++) begin
         wr(6'h04, {b[1:0], 6'h2A});
         wr(6'h00, {b[1:0], 6'h15});
      end
      wr(6'h10, 8'hC6);
      for (int b = 0; b < 4; b++) begin
         wr(6'h04, {b[1:0], 6'h00});
         rd(6'h2A, {b[1:0], 6'h15});
         rd(6'h10, 8'hC6);
      end
      $display("ram banking done");
      wr(6'h01, r[15:8]);
      counter_control_setting <= 1'b1;
      pulse(1, 3);
      pulse(0, 2);
      rd(6'h01, 8'(r[15:8] + 8'h03));
      counter_control_setting <= 1'b0;
      pulse(1, 2);
      pulse(0, 4);
      rd(6'h01, 8'(r[15:8] + 8'h07));
      $display("free counter done");
      wr(6'h05, 8'h02);
      ev(OP_JUMP, {2'h3, r[7:0]}, 8'h00, 1'b1, {2'h2, 2'h3, r[7:0]});
      ev(OP_STEP, 10'h000, 8'h00, 1'b1, m_pc + 12'h001);
      ev(OP_TABLE_JUMP, 10'h000, r[23:16], 1'b1, {m_pc[11:8], 8'(m_pc[7:0] + r[23:16])});
      ev(OP_ADD_PC, 10'h000, r[31:24], 1'b1, {4'h8, 8'(m_pc[7:0] + r[31:24])});
      ev(OP_PAGE, 10'h003, 8'h00, 1'b0, m_pc);
      rd(6'h05, 8'h03);
      ev(OP_MOV_PC, 10'h000, r[15:8], 1'b1, {4'hC, r[15:8]});
      for (int i = 0; i < 2; i++) begin
         ret = m_pc + 12'h001;
         ev(OP_CALL, r[25:16], 8'h00, 1'b1, {2'h3, r[25:16]});
         ev(i == 0 ? OP_RETURN : OP_LITERAL_RETURN, 10'h000, 8'h00, 1'b1, ret);
      end
      $display("program counter done");
      wr(6'h05, 8'h01);
      wr(6'h03, 8'h25);
      sav_acc = r[7:0];
      ret = m_pc;
      ev(OP_INTERRUPT, 10'h000, sav_acc, 1'b1, 12'h008);
      wr(6'h03, 8'hC2);
      rd(6'h05, 8'h00);
      ev(OP_INTERRUPT_RETURN, 10'h000, 8'h00, 1'b1, ret);
      rd(6'h03, 8'h3D);
      rd(6'h05, 8'h01);
      $display("interrupt context done");
      flags_in <= r[2:0];
      pulse(3, 1);
      rd(6'h03, {5'h07, r[2:0]});
      for (int i = 0; i < 4; i++) begin
         if (i == 1 || i == 3) pulse(2, 1);
         else ev(i == 0 ? OP_SLEEP : OP_WATCHDOG_CLEAR, 10'h000, 8'h00, 1'b0, m_pc);
         rd(6'h03, {3'h1, tp[i], r[2:0]});
      end
      $display("power flags done");
      repeat (2) @(posedge clk);
      if (q.size() != 0) begin
         bad_count++;
         $display("[ERR] pending_notes expected %0d seen %0d", 0, q.size());
      end
      stop_test();
   end
endmodule
